// *** hw/cae_exec_core.sv ***
`timescale 1ns/10ps
`default_nettype none

module cae_exec_core (
  input  wire logic              mclk_i,        // Core clock, 100 MHz.
  input  wire logic              arst_n_i,      // Asynchronous reset.
  input  wire logic              instr_valid_i, // Instruction offered.
  input  wire cae_pkg::cae_instr_s instr_i,     // Instruction bytes.
  input  wire logic [15:0]       pc_i,          // Address of first byte.
  input  wire logic [31:0]       port_pin_i,    // Pin levels, four ports.
  output logic                   busy_o,        // Instruction in flight.
  output logic                   done_o,        // Instruction retired.
  output logic                   pc_load_o,     // Load the jump target.
  output logic [15:0]            pc_target_o,   // Jump target.
  output logic [7:0]             acc_o,         // Accumulator.
  output logic [7:0]             psw_o,         // Status word.
  output logic [31:0]            port_latch_o   // Port output latches.
);

  // ------------------------------------------------------------------------
  // State.
  // ------------------------------------------------------------------------
  cae_pkg::cae_state_e state_ff, nxt_state;  // Sequencer.
  cae_pkg::cae_kind_e  kind_ff, nxt_kind;    // Instruction in flight.
  cae_pkg::cae_instr_s ins_ff, nxt_ins;      // Its bytes.
  logic [15:0]         pc_ff, nxt_pc;        // Its address.
  logic [7:0]          addr_ff, nxt_addr;    // Operand address.
  logic [7:0]          opnd_ff, nxt_opnd;    // Fetched operand.
  logic [7:0]          acc_ff, nxt_acc;      // Accumulator.
  logic [7:0]          psw_ff, nxt_psw;      // Status word.
  logic [3:0][7:0]     latch_ff, nxt_latch;  // Port latches.
  logic                done_ff, nxt_done;    // Retire pulse.
  logic                busy_ff, nxt_busy;    // Busy level.
  logic                pcld_ff, nxt_pcld;    // Jump pulse.
  logic [15:0]         tgt_ff, nxt_tgt;      // Jump target.
  logic [31:0]         pin_meta_ff;          // First synchroniser stage.
  logic [31:0]         pin_sync_ff;          // Second synchroniser stage.

  // Memory port signals.
  logic       mem_we;    // Write strobe.
  logic [7:0] mem_waddr; // Write address.
  logic [7:0] mem_wdata; // Write data.
  logic [7:0] mem_raddr; // Read address.
  logic [7:0] mem_rdata; // Read data.

  // Helpers for the datapath.
  cae_pkg::cae_kind_e new_kind; // Decode of the offered opcode.
  logic       is_port;          // Operand address is a port latch.
  logic [1:0] port_idx;         // Which port.
  logic       rmw;              // Direct destination forms.
  logic [7:0] dir_val;          // Value read at a direct address.
  logic [7:0] mask;             // Mask for direct destination forms.
  logic [7:0] anl_res;          // Result of a direct destination AND.
  logic [4:0] sum_lo;           // Sum of low nibbles with carry.
  logic [7:0] sum_mid;          // Sum of low seven bits with carry.
  logic [8:0] sum_full;         // Full sum with carry.
  logic [15:0] pc_plus2;        // Address of the next instruction.

  // ------------------------------------------------------------------------
  // Memory.
  // ------------------------------------------------------------------------
  // Lower half holds register banks and scratch RAM; upper half holds
  // the special function registers that this block does not own.
  cae_byte_ram #(
    .W  (8),
    .AW (8)
  ) u_ram (
    .mclk_i  (mclk_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // ------------------------------------------------------------------------
  // Datapath helpers.
  // ------------------------------------------------------------------------
  // Decode of the offered opcode from instr_i, then operand fetch and arithmetic from registered state.
  always_comb
  begin
    new_kind = cae_pkg::decode(instr_i.opc);
    is_port  = (addr_ff[7:6] == cae_pkg::PORT_HI) &&
               (addr_ff[3:0] == cae_pkg::PORT_LO);
    port_idx = addr_ff[5:4];
    rmw      = (kind_ff == cae_pkg::K_ANL_DA) ||
               (kind_ff == cae_pkg::K_ANL_DI);
    // A read-modify-write on a port starts from the latch, since the pin
    // may be held low by the outside and would corrupt the other bits.
    if (is_port)
    begin
      dir_val = rmw ? latch_ff[port_idx]
                    : pin_sync_ff[port_idx*8 +: 8];
    end
    else if (addr_ff == cae_pkg::SFR_ACC)
    begin
      dir_val = acc_ff;
    end
    else if (addr_ff == cae_pkg::SFR_PSW)
    begin
      dir_val = psw_ff;
    end
    else
    begin
      dir_val = mem_rdata;
    end
    mask     = (kind_ff == cae_pkg::K_ANL_DA) ? acc_ff : ins_ff.op2;
    anl_res  = opnd_ff & mask;
    sum_lo   = {1'b0, acc_ff[3:0]} + {1'b0, opnd_ff[3:0]} +
               {4'h0, psw_ff[cae_pkg::PSW_CY]};
    sum_mid  = {1'b0, acc_ff[6:0]} + {1'b0, opnd_ff[6:0]} +
               {7'h00, psw_ff[cae_pkg::PSW_CY]};
    sum_full = {1'b0, acc_ff} + {1'b0, opnd_ff} +
               {8'h00, psw_ff[cae_pkg::PSW_CY]};
    pc_plus2 = pc_ff + cae_pkg::PC_STEP;
  end

  // ------------------------------------------------------------------------
  // Sequencer and execution.
  // ------------------------------------------------------------------------
  // Offers are only taken in idle; unknown opcodes are left alone.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_kind  = kind_ff;
    nxt_ins   = ins_ff;
    nxt_pc    = pc_ff;
    nxt_addr  = addr_ff;
    nxt_opnd  = opnd_ff;
    nxt_acc   = acc_ff;
    nxt_psw   = psw_ff;
    nxt_latch = latch_ff;
    nxt_done  = 1'b0;
    nxt_pcld  = 1'b0;
    nxt_tgt   = tgt_ff;
    mem_raddr = addr_ff;
    mem_we    = 1'b0;
    mem_waddr = addr_ff;
    mem_wdata = anl_res;
    case (state_ff)
      cae_pkg::ST_IDLE:
      begin
        if (instr_valid_i && (new_kind != cae_pkg::K_NONE))
        begin
          nxt_kind  = new_kind;
          nxt_ins   = instr_i;
          nxt_pc    = pc_i;
          nxt_opnd  = instr_i.op1;
          nxt_addr  = instr_i.op1;
          nxt_state = cae_pkg::ST_EXEC;
          case (new_kind)
            cae_pkg::K_ANL_RN:
            begin
              // Register within the bank picked by the status word.
              nxt_addr  = {3'h0, psw_ff[cae_pkg::PSW_RS1:cae_pkg::PSW_RS0],
                           instr_i.opc[2:0]};
              nxt_state = cae_pkg::ST_OPND;
            end
            cae_pkg::K_ANL_IND:
            begin
              // Fetch the pointer register R0 or R1 first.
              nxt_addr  = {3'h0, psw_ff[cae_pkg::PSW_RS1:cae_pkg::PSW_RS0],
                           2'h0, instr_i.opc[0]};
              nxt_state = cae_pkg::ST_PTR;
            end
            cae_pkg::K_ANL_DIR, cae_pkg::K_ANL_DA, cae_pkg::K_ANL_DI:
            begin
              nxt_state = cae_pkg::ST_OPND;
            end
            default:
            begin
              nxt_state = cae_pkg::ST_EXEC;
            end
          endcase
          mem_raddr = nxt_addr;
        end
      end
      cae_pkg::ST_PTR:
      begin
        // Indirect reach covers the whole RAM, the register banks included.
        mem_raddr = mem_rdata;
        nxt_addr  = mem_rdata;
        nxt_state = cae_pkg::ST_OPND;
      end
      cae_pkg::ST_OPND:
      begin
        nxt_opnd  = (kind_ff == cae_pkg::K_ANL_IND) ? mem_rdata : dir_val;
        nxt_state = cae_pkg::ST_EXEC;
      end
      cae_pkg::ST_EXEC:
      begin
        nxt_done  = 1'b1;
        nxt_state = cae_pkg::ST_IDLE;
        case (kind_ff)
          cae_pkg::K_ADD_WITH_CARRY:
          begin
            nxt_acc                  = sum_full[7:0];
            nxt_psw[cae_pkg::PSW_CY] = sum_full[8];
            nxt_psw[cae_pkg::PSW_AC] = sum_lo[4];
            nxt_psw[cae_pkg::PSW_OV] = sum_mid[7] ^ sum_full[8];
          end
          cae_pkg::K_ABSOLUTE_JUMP_2K:
          begin
            // Only the low eleven bits of pc_plus2 change, so its page is kept.
            nxt_tgt  = {pc_plus2[15:11], ins_ff.opc[7:5],
                        ins_ff.op1};
            nxt_pcld = 1'b1;
          end
          cae_pkg::K_ANL_DA, cae_pkg::K_ANL_DI:
          begin
            // Destination decides where the result lands.
            if (is_port)
            begin
              nxt_latch[port_idx] = anl_res;
            end
            else if (addr_ff == cae_pkg::SFR_ACC)
            begin
              nxt_acc = anl_res;
            end
            else if (addr_ff == cae_pkg::SFR_PSW)
            begin
              nxt_psw = anl_res;
            end
            else
            begin
              mem_we = 1'b1;
            end
          end
          default:
          begin
            // Accumulator destination; flags stay as they are.
            nxt_acc = acc_ff & opnd_ff;
          end
        endcase
      end
      default:
      begin
        nxt_state = cae_pkg::ST_IDLE;
      end
    endcase
    nxt_busy = (nxt_state != cae_pkg::ST_IDLE);
  end

  // Registers only; pins pass two flip-flops before use.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff    <= cae_pkg::ST_IDLE;
      kind_ff     <= cae_pkg::K_NONE;
      ins_ff      <= '0;
      pc_ff       <= 16'h0000;
      addr_ff     <= 8'h00;
      opnd_ff     <= 8'h00;
      acc_ff      <= cae_pkg::ACC_RESET;
      psw_ff      <= cae_pkg::PSW_RESET;
      latch_ff    <= {4{cae_pkg::LATCH_RESET}};
      done_ff     <= 1'b0;
      busy_ff     <= 1'b0;
      pcld_ff     <= 1'b0;
      tgt_ff      <= 16'h0000;
      pin_meta_ff <= 32'h0000_0000;
      pin_sync_ff <= 32'h0000_0000;
    end
    else
    begin
      state_ff    <= nxt_state;
      kind_ff     <= nxt_kind;
      ins_ff      <= nxt_ins;
      pc_ff       <= nxt_pc;
      addr_ff     <= nxt_addr;
      opnd_ff     <= nxt_opnd;
      acc_ff      <= nxt_acc;
      psw_ff      <= nxt_psw;
      latch_ff    <= nxt_latch;
      done_ff     <= nxt_done;
      busy_ff     <= nxt_busy;
      pcld_ff     <= nxt_pcld;
      tgt_ff      <= nxt_tgt;
      pin_meta_ff <= port_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign busy_o       = busy_ff;
  assign done_o       = done_ff;
  assign pc_load_o    = pcld_ff;
  assign pc_target_o  = tgt_ff;
  assign acc_o        = acc_ff;
  assign psw_o        = psw_ff;
  assign port_latch_o = latch_ff;

  // ------------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  logic exec_add_with_carry; // Executing add-with-carry.
  logic exec_anl;  // Executing any AND form.
  assign exec_add_with_carry = (state_ff == cae_pkg::ST_EXEC) &&
                     (kind_ff == cae_pkg::K_ADD_WITH_CARRY);
  assign exec_anl  = (state_ff == cae_pkg::ST_EXEC) &&
                     (kind_ff inside {cae_pkg::K_ANL_RN, cae_pkg::K_ANL_DIR,
                      cae_pkg::K_ANL_IND, cae_pkg::K_ANL_IMM,
                      cae_pkg::K_ANL_DA, cae_pkg::K_ANL_DI});

  sequence s_take_jump;
    busy_ff == 1'b0 && instr_valid_i && instr_i.opc[4:0] == 5'h01;
  endsequence
  sequence s_take_direct;
    busy_ff == 1'b0 && instr_valid_i && instr_i.opc == 8'h55;
  endsequence

  property p_add_with_carry_sum;
    exec_add_with_carry |=> acc_ff == 8'($past(acc_ff) + $past(opnd_ff) +
                  {7'h00, $past(psw_ff[7])});
  endproperty
  a_add_with_carry_sum: assert property (p_add_with_carry_sum)
    else $error("add_with_carry sum wrong");

  property p_add_with_carry_flags;
    exec_add_with_carry |=> psw_ff[7] == $past(sum_full[8]) &&
                  psw_ff[6] == $past(sum_lo[4]);
  endproperty
  a_add_with_carry_flags: assert property (p_add_with_carry_flags)
    else $error("add_with_carry cy/ac wrong");

  property p_add_with_carry_ov;
    exec_add_with_carry |=> psw_ff[2] == ($past(sum_mid[7]) ^ $past(sum_full[8]));
  endproperty
  a_add_with_carry_ov: assert property (p_add_with_carry_ov)
    else $error("add_with_carry ov wrong");

  property p_jump_target;
    s_take_jump ##1 1'b1 |=> pc_load_o &&
      pc_target_o == {$past(pc_plus2[15:11]), $past(instr_i.opc[7:5], 2),
                      $past(instr_i.op1, 2)};
  endproperty
  // The offered bytes are taken two edges back, at the take itself.
  a_jump_target: assert property (p_jump_target)
    else $error("jump target wrong");

  property p_jump_two;
    s_take_jump |=> state_ff == cae_pkg::ST_EXEC ##1 done_o && pc_load_o;
  endproperty
  a_jump_two: assert property (p_jump_two)
    else $error("jump not two cycles");

  property p_direct_seq;
    s_take_direct |=> state_ff == cae_pkg::ST_OPND ##1
                      state_ff == cae_pkg::ST_EXEC ##1 done_o;
  endproperty
  a_direct_seq: assert property (p_direct_seq)
    else $error("direct and order");

  property p_anl_flags;
    exec_anl && addr_ff != 8'hD0 |=> psw_ff == $past(psw_ff);
  endproperty
  a_anl_flags: assert property (p_anl_flags)
    else $error("and touched flags");

  property p_anl_acc;
    exec_anl && !rmw |=> acc_ff == ($past(acc_ff) & $past(opnd_ff));
  endproperty
  a_anl_acc: assert property (p_anl_acc)
    else $error("and into acc wrong");

  property p_port_latch;
    state_ff == cae_pkg::ST_OPND && rmw && is_port |=>
      opnd_ff == $past(latch_ff[port_idx]);
  endproperty
  a_port_latch: assert property (p_port_latch)
    else $error("port not from latch");

  property p_anl_ram;
    exec_anl && rmw && !is_port && !addr_ff[7] |->
      mem_we && mem_wdata == (opnd_ff & mask);
  endproperty
  a_anl_ram: assert property (p_anl_ram)
    else $error("and to ram wrong");

endmodule

`default_nettype wire

// *** hw/cae_pkg.sv ***
package cae_pkg;

  // ----------------------------------------------------------------------
  // Opcodes of the three instruction groups handled by the block.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_ADD_WITH_CARRY_IMM = 8'h34; // Add-with-carry, immediate.
  localparam logic [4:0] OPC_ABSOLUTE_JUMP_2K_LO  = 5'h01; // Low five bits of the jump.
  localparam logic [4:0] OPC_ANL_RN   = 5'h0B; // Upper five bits, Rn form.
  localparam logic [7:0] OPC_ANL_DIR  = 8'h55; // Accumulator and direct.
  localparam logic [6:0] OPC_ANL_IND  = 7'h2B; // Upper seven bits, @Ri.
  localparam logic [7:0] OPC_ANL_IMM  = 8'h54; // Accumulator and immediate.
  localparam logic [7:0] OPC_ANL_DA   = 8'h52; // Direct and accumulator.
  localparam logic [7:0] OPC_ANL_DI   = 8'h53; // Direct and immediate.

  // ----------------------------------------------------------------------
  // Special function register addresses and status word layout.
  // ----------------------------------------------------------------------
  localparam logic [7:0] SFR_ACC      = 8'hE0; // Accumulator address.
  localparam logic [7:0] SFR_PSW      = 8'hD0; // Status word address.
  localparam logic [1:0] PORT_HI      = 2'h2;  // Bits 7:6 of a port address.
  localparam logic [3:0] PORT_LO      = 4'h0;  // Bits 3:0 of a port address.
  localparam int         PSW_CY       = 7;     // Carry flag.
  localparam int         PSW_AC       = 6;     // Auxiliary carry flag.
  localparam int         PSW_RS1      = 4;     // Register bank, high bit.
  localparam int         PSW_RS0      = 3;     // Register bank, low bit.
  localparam int         PSW_OV       = 2;     // Overflow flag.
  localparam logic [7:0] PSW_RESET    = 8'h00; // Status word after reset.
  localparam logic [7:0] ACC_RESET    = 8'h00; // Accumulator after reset.
  localparam logic [7:0] LATCH_RESET  = 8'hFF; // Port latches after reset.
  localparam logic [15:0] PC_STEP     = 16'h0002; // Jump length in bytes.

  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  // Sequencer states, Gray coded along idle, pointer, operand, execute.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PTR  = 2'b01,
    ST_OPND = 2'b11,
    ST_EXEC = 2'b10
  } cae_state_e;

  // Decoded instruction kinds.
  typedef enum logic [3:0] {
    K_NONE, K_ADD_WITH_CARRY, K_ABSOLUTE_JUMP_2K, K_ANL_RN, K_ANL_DIR,
    K_ANL_IND, K_ANL_IMM, K_ANL_DA, K_ANL_DI
  } cae_kind_e;

  // Instruction bytes as delivered by fetch.
  typedef struct packed {
    logic [7:0] opc; // First byte.
    logic [7:0] op1; // Second byte.
    logic [7:0] op2; // Third byte.
  } cae_instr_s;

  // Map an opcode to its kind; anything else is not handled here.
  function automatic cae_kind_e decode(input logic [7:0] opc);
    cae_kind_e k;
    k = K_NONE;
    if (opc == OPC_ADD_WITH_CARRY_IMM) k = K_ADD_WITH_CARRY;
    else if (opc[4:0] == OPC_ABSOLUTE_JUMP_2K_LO) k = K_ABSOLUTE_JUMP_2K;
    else if (opc[7:3] == OPC_ANL_RN) k = K_ANL_RN;
    else if (opc == OPC_ANL_DIR) k = K_ANL_DIR;
    else if (opc[7:1] == OPC_ANL_IND) k = K_ANL_IND;
    else if (opc == OPC_ANL_IMM) k = K_ANL_IMM;
    else if (opc == OPC_ANL_DA) k = K_ANL_DA;
    else if (opc == OPC_ANL_DI) k = K_ANL_DI;
    return k;
  endfunction

endpackage

// *** hw/cae_byte_ram.sv ***
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------------------
// Internal byte memory with one write port and a registered read port.
// --------------------------------------------------------------------------
module cae_byte_ram #(
  parameter int W  = 8,   // Data width.
  parameter int AW = 8    // Address width; depth is two to this power.
) (
  input  wire logic          mclk_i,  // Core clock.
  input  wire logic          we_i,    // Write strobe.
  input  wire logic [AW-1:0] waddr_i, // Write address.
  input  wire logic [W-1:0]  wdata_i, // Write data.
  input  wire logic [AW-1:0] raddr_i, // Read address.
  output logic      [W-1:0]  rdata_o  // Read data, one cycle later.
);

  logic [W-1:0] mem_ff [2**AW]; // Storage; no reset, like real RAM.

  // Write and read in one process; read data come from a register.
  always_ff @(posedge mclk_i)
  begin
    if (we_i)
    begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_ff[raddr_i];
  end

endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_top;

  // ------------------------------------------------------------------------
  // Signals and the bench's own model of the architectural state.
  // ------------------------------------------------------------------------
  logic                mclk_i;        // Core clock.
  logic                arst_n_i;      // Reset, active low.
  logic                instr_valid_i; // Offer strobe.
  cae_pkg::cae_instr_s instr_i;       // Offered bytes.
  logic [15:0]         pc_i;          // Address of the first byte.
  logic [31:0]         port_pin_i;    // Pin levels.
  logic                busy_o;        // Instruction in flight.
  logic                done_o;        // Retire pulse.
  logic                pc_load_o;     // Jump strobe.
  logic [15:0]         pc_target_o;   // Jump target.
  logic [7:0]          acc_o;         // Accumulator.
  logic [7:0]          psw_o;         // Status word.
  logic [31:0]         port_latch_o;  // Port latches.
  logic [64:0]         exp_q [$];     // Expected results, oldest first.
  logic [7:0]          m_acc;         // Model accumulator.
  logic [7:0]          m_psw;         // Model status word.
  logic [31:0]         m_lat;         // Model port latches.
  logic [15:0]         m_tgt;         // Model jump target.
  logic [7:0]          add_tab [4];   // Boundary addends.
  logic [15:0]         pc_tab [4];    // Awkward jump addresses.
  int                  errors;        // Mismatches seen.
  int                  tests_run;     // Comparisons made.
  int                  cyc;           // Cycles since time zero.

  cae_exec_core uut (
    .mclk_i        (mclk_i),
    .arst_n_i      (arst_n_i),
    .instr_valid_i (instr_valid_i),
    .instr_i       (instr_i),
    .pc_i          (pc_i),
    .port_pin_i    (port_pin_i),
    .busy_o        (busy_o),
    .done_o        (done_o),
    .pc_load_o     (pc_load_o),
    .pc_target_o   (pc_target_o),
    .acc_o         (acc_o),
    .psw_o         (psw_o),
    .port_latch_o  (port_latch_o)
  );

  // ------------------------------------------------------------------------
  // Clock, timeout and the shared comparison and closing tasks.
  // ------------------------------------------------------------------------
  // The clock toggles every 5 ns, half of its 10 ns period.
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // A hang is cut short well beyond the roughly 170 cycles the run needs.
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      end_of_test();
    end
  end

  // Compares a seen value with its expectation and reports any mismatch.
  task automatic check(input logic [64:0] seen, input logic [64:0] want);
    tests_run++;
    if (seen !== want)
    begin
      errors++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------------------
  // Monitor: each retire pulse takes the oldest note off the queue.
  // ------------------------------------------------------------------------
  // An unexpected pulse with an empty queue counts as a mismatch.
  always @(posedge mclk_i)
  begin
    #1;
    if (done_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(65'h1, 65'h0);
      else
        check({pc_load_o, pc_target_o, acc_o, psw_o, port_latch_o},
              exp_q.pop_front());
    end
  end

  // ------------------------------------------------------------------------
  // Driver: models the instruction, notes the result, offers it, times it.
  // ------------------------------------------------------------------------
  task automatic run(input logic [7:0] opc, input logic [7:0] op1,
                     input logic [7:0] op2, input logic [15:0] pc,
                     input int lat);
    logic [8:0]  s;
    logic [4:0]  h;
    logic [7:0]  q;
    logic [7:0]  v;
    logic [15:0] t;
    logic        c;
    int          n;
    c = m_psw[7];
    n = 0;
    v = 8'h00;
    if (op1 == 8'hE0)
      v = m_acc;
    else if (op1 == 8'hD0)
      v = m_psw;
    else if (op1[7:6] == 2'h2 && op1[3:0] == 4'h0)
      v = (opc == 8'h55) ? port_pin_i[{op1[5:4], 3'b000} +: 8]
                         : m_lat[{op1[5:4], 3'b000} +: 8];
    if (opc == 8'h34)
    begin
      s = m_acc + op1 + c;
      h = m_acc[3:0] + op1[3:0] + c;
      q = m_acc[6:0] + op1[6:0] + c;
      m_psw[7] = s[8];
      m_psw[6] = h[4];
      m_psw[2] = s[8] ^ q[7];
      m_acc = s[7:0];
    end
    else if (opc[4:0] == 5'h01)
    begin
      t = pc + 16'h0002;
      m_tgt = {t[15:11], opc[7:5], op1};
    end
    else if (opc == 8'h54)
      m_acc = m_acc & op1;
    else if (opc == 8'h55)
      m_acc = m_acc & v;
    else if (opc == 8'h52 || opc == 8'h53)
    begin
      v = v & ((opc == 8'h52) ? m_acc : op2);
      if (op1 == 8'hE0)
        m_acc = v;
      else if (op1 == 8'hD0)
        m_psw = v;
      else if (op1[7:6] == 2'h2 && op1[3:0] == 4'h0)
        m_lat[{op1[5:4], 3'b000} +: 8] = v;
    end
    else
      m_acc = 8'h00;
    exp_q.push_back({opc[4:0] == 5'h01, m_tgt, m_acc, m_psw, m_lat});
    instr_valid_i = 1'b1;
    instr_i = '{opc: opc, op1: op1, op2: op2};
    pc_i = pc;
    // The take edge counts as the first; busy must show just after it.
    @(posedge mclk_i);
    #1;
    n = 1;
    check({64'h0, busy_o}, 65'h1);
    @(negedge mclk_i);
    instr_valid_i = 1'b0;
    do
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    while (done_o !== 1'b1 && n < 8);
    check(n, lat);
    @(negedge mclk_i);
  endtask

  // ------------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------------
  initial
  begin
    arst_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = '0;
    pc_i = 16'h0000;
    port_pin_i = 32'h00000000;
    {m_acc, m_psw, m_lat, m_tgt} = {16'h0000, 32'hFFFFFFFF, 16'h0000};
    add_tab = '{8'hFF, 8'h7F, 8'h80, 8'h0F};
    pc_tab = '{16'h0345, 16'h07FE, 16'hFFFE, 16'h17FD};
    void'($urandom(32'h29752039));
    repeat (6) @(negedge mclk_i);
    arst_n_i = 1'b1;
    check({done_o, pc_target_o, acc_o, psw_o, port_latch_o},
          {1'b0, 16'h0000, 16'h0000, 32'hFFFFFFFF});
    port_pin_i = $urandom;
    repeat (3) @(negedge mclk_i);
    for (int i = 0; i < 10; i++)
      run(8'h34, (i < 4) ? add_tab[i] : 8'($urandom), 8'h00, 16'h0000, 2);
    $display("add test done");
    for (int i = 0; i < 8; i++)
      run({i[2:0], 5'h01}, 8'($urandom), 8'h00, pc_tab[i % 4], 2);
    $display("jump test done");
    // Every port, the accumulator and the status word as direct source, each after a fresh accumulator value.
    for (int i = 0; i < 6; i++)
    begin
      run(8'h34, 8'($urandom), 8'h00, 16'h0000, 2);
      run(8'h54, 8'($urandom), 8'h00, 16'h0000, 2);
      run(8'h34, 8'($urandom), 8'h00, 16'h0000, 2);
      run(8'h55, (i < 4) ? {2'h2, i[1:0], 4'h0} : ((i == 4) ? 8'hE0 : 8'hD0),
          8'h00, 16'h0000, 3);
    end
    // Ports are masked from the latch while the pins show other levels.
    run(8'h53, 8'h90, 8'h73, 16'h0000, 3);
    for (int i = 0; i < 4; i++)
    begin
      run(8'h34, 8'($urandom), 8'h00, 16'h0000, 2);
      run(8'h52, {2'h2, i[1:0], 4'h0}, 8'h00, 16'h0000, 3);
    end
    // Bank bits stay clear, so the register tests below use bank zero.
    run(8'h53, 8'hD0, 8'($urandom) & 8'hE7, 16'h0000, 3);
    run(8'h53, 8'hE0, 8'($urandom), 16'h0000, 3);
    $display("direct test done");
    // Memory is not reset, so only cleared bytes give known operands.
    run(8'h53, 8'h00, 8'h00, 16'h0000, 3);
    run(8'h53, 8'h01, 8'h00, 16'h0000, 3);
    for (int i = 0; i < 5; i++)
    begin
      run(8'h34, 8'($urandom), 8'h00, 16'h0000, 2);
      run((i < 2) ? 8'h58 + 8'(i) : ((i < 4) ? 8'h54 + 8'(i) : 8'h55),
          8'h00, 8'h00, 16'h0000, (i == 4) ? 3 : ((i < 2) ? 3 : 4));
    end
    $display("memory test done");
    // An opcode outside the block must not retire.
    instr_valid_i = 1'b1;
    instr_i = '{opc: 8'hA5, op1: 8'h00, op2: 8'h00};
    @(negedge mclk_i);
    instr_valid_i = 1'b0;
    repeat (5) @(negedge mclk_i);
    check({64'h0, busy_o}, 65'h0);
    $display("ignore test done");
    end_of_test();
  end

endmodule

`default_nettype wire
